// *** src/mcu_instruction_execute_unit.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "exec_unit_params.svh"
// Contract
// - Subtract with borrow, carry set when none
// - Subtract, carry cleared on borrow
// - Add immediate, updates carry, half, zero
// - AND/OR/XOR change zero flag only
// - Nibble swap, no flag change
// - Rotate through carry, carry only
// - Clear byte, bit clear/set, no flags
// - Compare, set flags, skip if equal
// - Increment, skip if result zero
// - Decrement, skip if result zero
// - Test bit, skip when it matches
// - Jump loads target and page bits
// - Call pushes next address and jumps in the same cycle
// - Return pops PC; interrupt return enables
// - Push saves accumulator and flags except PD and TO
// - Pop restores accumulator and flags except PD and TO
// - Write-back cycle only for RAM
// - Taken skip adds one cycle
// - No-operation takes one cycle only
module mcu_instruction_execute_unit (
    input wire logic i_ref_clk,               // 20 MHz core clock
    input wire logic i_rst_n,                 // Async reset, active low
    input wire logic i_valid,                 // Instruction present
    input wire exec_unit_pkg::instr_t i_instr, // Decoded instruction
    input wire logic [7:0] i_mem_data,        // Memory operand value
    input wire logic [15:0] i_pc_next,        // Address after this one
    input wire logic [1:0] i_page_sel,        // Program page select bits
    input wire logic [15:0] i_stack_top,      // Popped return address
    output exec_unit_pkg::result_t o_result,  // Write-back and timing
    output logic o_done,                      // Result valid pulse
    output logic [7:0] o_acc,                 // Accumulator
    output logic [7:0] o_flags,               // Program flag register
    output logic o_pc_load,                   // PC reload pulse
    output logic [15:0] o_pc,                 // New PC value
    output logic o_stack_push,                // Push return address
    output logic [15:0] o_stack_data,         // Address pushed
    output logic o_int_enable                 // Global interrupt enable
);
    import exec_unit_pkg::*;

    logic [7:0] acc_reg;
    logic [7:0] flags_reg;
    logic [7:0] acc_save_reg;     // Push buffer for accumulator
    logic [7:0] flags_save_reg;   // Push buffer for flags
    result_t result_reg;
    logic done_reg;
    logic pc_load_reg;
    logic [15:0] pc_reg;
    logic push_reg;
    logic [15:0] push_data_reg;
    logic gie_reg;

    // Operand select: immediate or memory byte
    wire [7:0] opnd = i_instr.use_imm ? i_instr.imm : i_mem_data;
    wire cin = flags_reg[`FLAG_CARRY];
    wire [4:0] op = i_instr.op;

    // Shared adder; add, subtract and subtract-with-borrow
    wire is_add = (op == `OP_ADD_IMM);
    wire is_sbc = (op == `OP_SUB_BORROW);
    wire [7:0] b_in = is_add ? opnd : ~opnd;
    // Subtract as A + ~M + 1, borrow folded in as carry-in = C
    wire carry_in = is_add ? 1'b0 : (is_sbc ? cin : 1'b1);
    wire [8:0] sum9 = {1'b0, acc_reg} + {1'b0, b_in} + {8'h00, carry_in};
    wire [4:0] half5 = {1'b0, acc_reg[3:0]} + {1'b0, b_in[3:0]}
                     + {4'h0, carry_in};
    wire [7:0] sum = sum9[7:0];
    // Carry out of A + ~M + 1 means no borrow, so C=1 without borrow
    wire c_out = sum9[8];
    wire h_out = half5[4];

    wire [7:0] inc_val = i_mem_data + `ONE_BYTE;
    wire [7:0] dec_val = i_mem_data - `ONE_BYTE;
    wire [7:0] bit_mask = `ONE_BYTE << i_instr.bit_sel;
    wire tested_bit = i_mem_data[i_instr.bit_sel];
    wire [7:0] program_flag_register_keep = flags_reg & ~`FLAG_SAVE_MASK;
    wire [15:0] jump_pc = {i_page_sel, i_instr.target};
    wire n_term = i_instr.mem_is_ram & (op != `OP_CLEAR);

    // Combinational execution of one instruction
    logic [7:0] res_data;
    logic [7:0] flags_next;
    logic [7:0] acc_next;
    logic wr_acc;
    logic wr_mem;
    logic skip;
    logic branch;
    always_comb begin
        res_data = `ZERO_BYTE;
        flags_next = flags_reg;
        acc_next = acc_reg;
        wr_acc = 1'b0;
        wr_mem = 1'b0;
        skip = 1'b0;
        branch = 1'b0;
        unique case (op)
            `OP_ADD_IMM, `OP_SUB_BORROW, `OP_SUB: begin
                res_data = sum;
                flags_next[`FLAG_CARRY] = c_out;
                flags_next[`FLAG_HALF] = h_out;
                flags_next[`FLAG_ZERO] = (sum == `ZERO_BYTE);
                wr_acc = ~i_instr.to_mem;
                wr_mem = i_instr.to_mem;
            end
            `OP_AND, `OP_OR, `OP_XOR: begin
                if (op == `OP_AND) begin
                    res_data = acc_reg & opnd;
                end else if (op == `OP_OR) begin
                    res_data = acc_reg | opnd;
                end else begin
                    res_data = acc_reg ^ opnd;
                end
                flags_next[`FLAG_ZERO] = (res_data == `ZERO_BYTE);
                wr_acc = ~i_instr.to_mem;
                wr_mem = i_instr.to_mem;
            end
            `OP_SWAP: begin
                res_data = {i_mem_data[3:0], i_mem_data[7:4]};
                wr_acc = ~i_instr.to_mem;
                wr_mem = i_instr.to_mem;
            end
            `OP_ROT_RIGHT: begin
                res_data = {cin, i_mem_data[7:1]};
                flags_next[`FLAG_CARRY] = i_mem_data[0];
                wr_acc = ~i_instr.to_mem;
                wr_mem = i_instr.to_mem;
            end
            `OP_ROT_LEFT: begin
                res_data = {i_mem_data[6:0], cin};
                flags_next[`FLAG_CARRY] = i_mem_data[7];
                wr_acc = ~i_instr.to_mem;
                wr_mem = i_instr.to_mem;
            end
            `OP_CLEAR: begin
                res_data = `ZERO_BYTE;
                wr_mem = 1'b1;
            end
            `OP_BIT_CLEAR: begin
                res_data = i_mem_data & ~bit_mask;
                wr_mem = 1'b1;
            end
            `OP_BIT_SET: begin
                res_data = i_mem_data | bit_mask;
                wr_mem = 1'b1;
            end
            `OP_COMPARE_SKIP: begin
                // Difference only sets flags, never stored
                flags_next[`FLAG_CARRY] = c_out;
                flags_next[`FLAG_ZERO] = (sum == `ZERO_BYTE);
                skip = (acc_reg == opnd);
            end
            `OP_INC_SKIP: begin
                res_data = inc_val;
                skip = (inc_val == `ZERO_BYTE);
                wr_acc = ~i_instr.to_mem;
                wr_mem = i_instr.to_mem;
            end
            `OP_DEC_SKIP: begin
                res_data = dec_val;
                skip = (dec_val == `ZERO_BYTE);
                wr_acc = ~i_instr.to_mem;
                wr_mem = i_instr.to_mem;
            end
            `OP_TEST_LOW_SKIP: begin
                skip = ~tested_bit;
            end
            `OP_TEST_HIGH_SKIP: begin
                skip = tested_bit;
            end
            `OP_JUMP, `OP_CALL, `OP_RETURN, `OP_INT_RETURN: begin
                branch = 1'b1;
            end
            `OP_PUSH: begin
                // Save handled in the buffer process
            end
            `OP_POP: begin
                // Status bits stay as they are
                acc_next = acc_save_reg;
                flags_next = program_flag_register_keep
                           | (flags_save_reg & `FLAG_SAVE_MASK);
            end
            default: begin
                // Unused codes behave as no-operation
            end
        endcase
        if (wr_acc) begin
            acc_next = res_data;
        end
    end

    // Cycle count: 1 + N + S, or 2 for branches
    wire [2:0] cyc_base = {1'b0, `CYC_BASE};
    wire [2:0] cyc_total = branch ? {1'b0, `CYC_BRANCH} :
        cyc_base + {2'b00, n_term & wr_mem} + {2'b00, skip};

    wire [15:0] pc_sel = (op == `OP_RETURN || op == `OP_INT_RETURN) ?
                         i_stack_top : jump_pc;
    wire is_call = i_valid & (op == `OP_CALL);
    wire is_interrupt_return = i_valid & (op == `OP_INT_RETURN);
    wire is_push = i_valid & (op == `OP_PUSH);

    // Architectural state update
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acc_reg <= `ZERO_BYTE;
            flags_reg <= `ZERO_BYTE;
        end else if (i_valid) begin
            acc_reg <= acc_next;
            flags_reg <= flags_next;
        end
    end

    // Push buffers, status bits excluded
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acc_save_reg <= `ZERO_BYTE;
            flags_save_reg <= `ZERO_BYTE;
        end else if (is_push) begin
            acc_save_reg <= acc_reg;
            flags_save_reg <= flags_reg & `FLAG_SAVE_MASK;
        end
    end

    // Result and program flow outputs
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            result_reg <= '0;
            done_reg <= 1'b0;
            pc_load_reg <= 1'b0;
            pc_reg <= `ZERO_PC;
            push_reg <= 1'b0;
            push_data_reg <= `ZERO_PC;
        end else begin
            result_reg <= '{acc_we: i_valid & wr_acc,
                            mem_we: i_valid & wr_mem,
                            data: res_data, skip: i_valid & skip,
                            cycles: cyc_total};
            done_reg <= i_valid;
            pc_load_reg <= i_valid & branch;
            pc_reg <= pc_sel;
            push_reg <= is_call;
            push_data_reg <= i_pc_next;
        end
    end

    // Global interrupt enable; only interrupt return sets it here
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gie_reg <= 1'b0;
        end else if (is_interrupt_return) begin
            gie_reg <= 1'b1;
        end
    end

    assign o_result = result_reg;
    assign o_done = done_reg;
    assign o_acc = acc_reg;
    assign o_flags = flags_reg;
    assign o_pc_load = pc_load_reg;
    assign o_pc = pc_reg;
    assign o_stack_push = push_reg;
    assign o_stack_data = push_data_reg;
    assign o_int_enable = gie_reg;

    // Checks beside the logic
    property p_skip_cycles;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        o_done && o_result.skip && !o_pc_load |-> o_result.cycles >= 3'h2;
    endproperty
    a_skip_cycles: assert property (p_skip_cycles)
        else $error("Taken skip lacks extra cycle");

    property p_branch_two;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        o_pc_load |-> o_result.cycles == 3'h2;
    endproperty
    a_branch_two: assert property (p_branch_two)
        else $error("Branch not two cycles");

    property p_call_push;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_valid && op == `OP_CALL) |=> o_stack_push && o_pc_load
            && o_stack_data == $past(i_pc_next);
    endproperty
    a_call_push: assert property (p_call_push)
        else $error("Call did not push address");

    property p_interrupt_return_gie;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        is_interrupt_return |=> o_int_enable && o_pc == $past(i_stack_top);
    endproperty
    a_interrupt_return_gie: assert property (p_interrupt_return_gie)
        else $error("Interrupt return wrong");

    property p_nop_still;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_valid && op == `OP_NOP) |=> $stable(o_acc) && $stable(o_flags)
            && o_result.cycles == 3'h1 && !o_result.mem_we;
    endproperty
    a_nop_still: assert property (p_nop_still)
        else $error("No-operation changed state");

    property p_pop_status;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_valid && op == `OP_POP) |=>
            o_flags[`FLAG_TO] == $past(flags_reg[`FLAG_TO]);
    endproperty
    a_pop_status: assert property (p_pop_status)
        else $error("Pop altered status bit");

    property p_logic_flags;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_valid && op >= `OP_AND && op <= `OP_XOR) |=>
            o_flags[`FLAG_CARRY] == $past(cin);
    endproperty
    a_logic_flags: assert property (p_logic_flags)
        else $error("Logic op touched carry");

    property p_ram_cycle;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_valid && op == `OP_BIT_SET && !i_instr.mem_is_ram) |=>
            o_result.cycles == 3'h1;
    endproperty
    a_ram_cycle: assert property (p_ram_cycle)
        else $error("System register write-back counted");
endmodule
`default_nettype wire

// *** src/exec_unit_params.svh ***
`ifndef EXEC_UNIT_PARAMS_SVH
`define EXEC_UNIT_PARAMS_SVH
// Opcode codes (5-bit operation field)
`define OP_NOP 5'h00
`define OP_ADD_IMM 5'h01
`define OP_SUB_BORROW 5'h02
`define OP_SUB 5'h03
`define OP_AND 5'h04
`define OP_OR 5'h05
`define OP_XOR 5'h06
`define OP_SWAP 5'h07
`define OP_ROT_RIGHT 5'h08
`define OP_ROT_LEFT 5'h09
`define OP_CLEAR 5'h0a
`define OP_BIT_CLEAR 5'h0b
`define OP_BIT_SET 5'h0c
`define OP_COMPARE_SKIP 5'h0d
`define OP_INC_SKIP 5'h0e
`define OP_DEC_SKIP 5'h0f
`define OP_TEST_LOW_SKIP 5'h10
`define OP_TEST_HIGH_SKIP 5'h11
`define OP_JUMP 5'h12
`define OP_CALL 5'h13
`define OP_RETURN 5'h14
`define OP_INT_RETURN 5'h15
`define OP_PUSH 5'h16
`define OP_POP 5'h17
// Flag register bit positions
`define FLAG_CARRY 0
`define FLAG_HALF 1
`define FLAG_ZERO 2
`define FLAG_PD 6
`define FLAG_TO 7
// Bits kept across push and pop (status bits excluded)
`define FLAG_SAVE_MASK 8'h3f
`define TARGET_MSB 13
`define ZERO_BYTE 8'h00
`define ONE_BYTE 8'h01
`define ZERO_PC 16'h0000
// Cycle counts
`define CYC_BASE 2'h1
`define CYC_BRANCH 2'h2
`endif

// *** src/exec_unit_pkg.sv ***
package exec_unit_pkg;
    // One decoded instruction with its operands
    typedef struct packed {
        logic [4:0] op;       // Operation code
        logic to_mem;         // Result goes to memory
        logic use_imm;        // Operand is the immediate
        logic mem_is_ram;     // Operand lives in RAM (not system reg)
        logic [2:0] bit_sel;  // Addressed bit
        logic [7:0] imm;      // Immediate byte
        logic [13:0] target;  // Jump/call target
    } instr_t;
    // Result of one executed instruction
    typedef struct packed {
        logic acc_we;        // Accumulator written
        logic mem_we;        // Memory operand written
        logic [7:0] data;    // Written value
        logic skip;          // Next instruction skipped
        logic [2:0] cycles;  // Cycles the instruction took
    } result_t;
endpackage

// *** bench/mcu_instruction_execute_unit_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "exec_unit_params.svh"
// Counted comparison, four-state exact
`define CHK(g, e) begin \
    num_checks++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("[ERR] %0t got %h want %h", $time, (g), (e)); \
    end \
end
module mcu_instruction_execute_unit_bench;
    import exec_unit_pkg::*;
    logic i_ref_clk = 1'b0; // Core clock
    logic i_rst_n = 1'b0; // Reset, active low
    logic i_valid = 1'b0; // Instruction strobe
    instr_t i_instr = '0; // Instruction under test
    logic [7:0] i_mem_data = 8'h00; // Memory operand
    logic [15:0] i_pc_next = 16'h0000; // Return address
    logic [1:0] i_page_sel = 2'h0; // Page bits
    logic [15:0] i_stack_top = 16'h0000; // Popped address
    result_t o_result;
    logic o_done, o_pc_load, o_stack_push, o_int_enable;
    logic [7:0] o_acc, o_flags;
    logic [15:0] o_pc, o_stack_data;
    int n_mismatch = 0;
    int num_checks = 0;
    // Reference state; half-carry after subtract is left unjudged
    logic [7:0] m_acc = 8'h00, m_flags = 8'h00;
    logic [7:0] s_acc = 8'h00, s_flags = 8'h00;
    logic m_ie = 1'b0, hk = 1'b1, s_hk = 1'b1;
    // Expected answer of the pending instruction
    result_t e_res;
    logic e_pend = 1'b0, e_we, e_load, e_push;
    logic [15:0] e_pc, e_sd;

    mcu_instruction_execute_unit u_mcu_instruction_execute_unit (
        .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_valid(i_valid),
        .i_instr(i_instr), .i_mem_data(i_mem_data),
        .i_pc_next(i_pc_next), .i_page_sel(i_page_sel),
        .i_stack_top(i_stack_top), .o_result(o_result), .o_done(o_done),
        .o_acc(o_acc), .o_flags(o_flags), .o_pc_load(o_pc_load),
        .o_pc(o_pc), .o_stack_push(o_stack_push),
        .o_stack_data(o_stack_data), .o_int_enable(o_int_enable)
    );

    // Free-running clock, 50 ns period
    always #25 i_ref_clk = ~i_ref_clk;

    // Reference model of one instruction
    function automatic void predict();
        logic [8:0] w;
        logic [7:0] a, m, mo, r;
        logic c, n, wa, wm;
        a = m_acc;
        m = i_instr.use_imm ? i_instr.imm : i_mem_data;
        mo = i_mem_data;
        c = m_flags[`FLAG_CARRY];
        n = i_instr.to_mem & i_instr.mem_is_ram;
        e_res = '0;
        e_res.cycles = 3'h1;
        {e_we, e_load, e_push, wa, wm, r} = {1'b1, 4'h0, a};
        e_pc = i_stack_top;
        e_sd = i_pc_next;
        case (i_instr.op)
            `OP_ADD_IMM: begin
                w = {1'b0, a} + {1'b0, i_instr.imm};
                r = w[7:0];
                m_flags[2] = (r == 8'h00);
                m_flags[0] = w[8];
                m_flags[1] = ({1'b0, a[3:0]} + {1'b0, i_instr.imm[3:0]}) > 5'h0f;
                {hk, wa} = 2'h3;
            end
            `OP_SUB_BORROW, `OP_SUB, `OP_COMPARE_SKIP: begin
                w = {1'b0, a} - {1'b0, m};
                if (i_instr.op == `OP_SUB_BORROW) w = w - {8'h00, ~c};
                r = w[7:0];
                m_flags[0] = ~w[8];
                m_flags[2] = (r == 8'h00);
                if (i_instr.op == `OP_COMPARE_SKIP) begin
                    e_res.skip = (a == m);
                    r = a;
                end else begin
                    hk = 1'b0;
                    {wm, wa} = {i_instr.to_mem, ~i_instr.to_mem};
                end
            end
            `OP_AND, `OP_OR, `OP_XOR: begin
                r = (i_instr.op == `OP_AND) ? (a & m) :
                    (i_instr.op == `OP_OR) ? (a | m) : (a ^ m);
                m_flags[2] = (r == 8'h00);
                {wm, wa} = {i_instr.to_mem, ~i_instr.to_mem};
            end
            `OP_SWAP, `OP_ROT_RIGHT, `OP_ROT_LEFT, `OP_INC_SKIP,
            `OP_DEC_SKIP: begin
                case (i_instr.op)
                    `OP_SWAP: r = {mo[3:0], mo[7:4]};
                    `OP_ROT_RIGHT: {r, m_flags[0]} = {c, mo};
                    `OP_ROT_LEFT: {m_flags[0], r} = {mo, c};
                    `OP_INC_SKIP: r = mo + 8'h01;
                    default: r = mo - 8'h01;
                endcase
                if (i_instr.op >= `OP_INC_SKIP) e_res.skip = (r == 8'h00);
                {wm, wa} = {i_instr.to_mem, ~i_instr.to_mem};
            end
            `OP_CLEAR: {wm, n, r} = {2'h2, 8'h00}; // One cycle even in RAM
            `OP_BIT_CLEAR, `OP_BIT_SET: begin
                r = mo;
                r[i_instr.bit_sel] = (i_instr.op == `OP_BIT_SET);
                wm = 1'b1;
            end
            `OP_TEST_LOW_SKIP, `OP_TEST_HIGH_SKIP:
                e_res.skip = mo[i_instr.bit_sel] == i_instr.op[0];
            `OP_JUMP, `OP_CALL, `OP_RETURN, `OP_INT_RETURN: begin
                e_res.cycles = 3'h2;
                e_load = 1'b1;
                if (i_instr.op <= `OP_CALL) e_pc = {i_page_sel, i_instr.target};
                e_push = (i_instr.op == `OP_CALL);
                if (i_instr.op == `OP_INT_RETURN) m_ie = 1'b1;
            end
            `OP_PUSH: begin
                {s_acc, s_flags, s_hk, e_we} = {a, m_flags & 8'h3f, hk, 1'b0};
            end
            `OP_POP: begin
                m_flags = (m_flags & 8'hc0) | (s_flags & 8'h3f);
                {r, hk, e_we} = {s_acc, s_hk, 1'b0};
            end
            default: ;
        endcase
        if (wa | wm) e_res.cycles = 3'h1 + {2'h0, wm & n};
        e_res.cycles = e_res.cycles + {2'h0, e_res.skip};
        {e_res.acc_we, e_res.mem_we, e_res.data} = {wa, wm, (wa | wm) ? r : 8'h00};
        if (wa | ~e_we) m_acc = r;
    endfunction

    // Compare outputs of the instruction taken at the last edge
    task automatic check();
        `CHK(o_done, e_pend)
        `CHK(o_pc_load, e_pend & e_load)
        `CHK(o_stack_push, e_pend & e_push)
        `CHK(o_int_enable, m_ie)
        `CHK(o_acc, m_acc)
        `CHK(o_flags & {6'h3d, hk, 1'b1}, m_flags & {6'h3d, hk, 1'b1})
        if (e_pend) begin
            `CHK(o_result.skip, e_res.skip)
            `CHK(o_result.cycles, e_res.cycles)
            if (e_we) `CHK(o_result[13:3], e_res[13:3])
            if (e_load) `CHK(o_pc, e_pc)
            if (e_push) `CHK(o_stack_data, e_sd)
        end
    endtask

    // Drive one instruction at the falling edge
    task automatic issue(input logic [4:0] op, input logic [7:0] imm,
                         input logic [7:0] mem, input logic [2:0] fl);
        @(negedge i_ref_clk);
        check();
        i_instr = {op, fl, 3'($urandom), imm, 14'($urandom)};
        if (op == `OP_ADD_IMM) {i_instr.use_imm, i_instr.to_mem} = 2'h2;
        if (i_instr.use_imm) i_instr.to_mem = 1'b0;
        if (op >= `OP_SWAP) i_instr.use_imm = 1'b0;
        if (op >= `OP_CLEAR && op <= `OP_BIT_SET) i_instr.to_mem = 1'b1;
        {i_mem_data, i_valid} = {mem, 1'b1};
        {i_pc_next, i_page_sel, i_stack_top} = 34'($urandom) ^ {$urandom, 2'h0};
        predict();
        e_pend = 1'b1;
    endtask

    // Verdict, the single end of the run
    task automatic stop_test();
        if (n_mismatch == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Watchdog against a hung sequence
    initial begin
        #(50 * 5000);
        n_mismatch++;
        stop_test();
    end

    // Main sequence: corners, then random traffic
    initial begin
        void'($urandom(29));
        repeat (2) @(negedge i_ref_clk);
        i_rst_n = 1'b1;
        issue(`OP_ADD_IMM, 8'hff, 8'h00, 3'h2);
        issue(`OP_ADD_IMM, 8'h01, 8'h00, 3'h2);
        issue(`OP_SUB_BORROW, 8'h00, 8'h00, 3'h0);
        issue(`OP_SUB, 8'h01, 8'h00, 3'h5);
        issue(`OP_COMPARE_SKIP, 8'hff, 8'h00, 3'h2);
        issue(`OP_INC_SKIP, 8'h00, 8'hff, 3'h5);
        issue(`OP_DEC_SKIP, 8'h00, 8'h01, 3'h4);
        issue(`OP_BIT_SET, 8'h00, 8'h00, 3'h1);
        issue(`OP_CLEAR, 8'h00, 8'h5a, 3'h1);
        issue(`OP_PUSH, 8'h00, 8'h00, 3'h0);
        issue(`OP_ROT_LEFT, 8'h00, 8'h80, 3'h0);
        issue(`OP_POP, 8'h00, 8'h00, 3'h0);
        issue(`OP_INT_RETURN, 8'h00, 8'h00, 3'h0);
        for (int k = 0; k < 32; k++) issue(5'(k), 8'($urandom), 8'($urandom), 3'h5);
        for (int k = 0; k < 800; k++) begin
            if ($urandom_range(7) == 0) begin
                @(negedge i_ref_clk);
                check();
                {i_valid, e_pend} = 2'h0;
            end else begin
                issue(5'($urandom), 8'($urandom), 8'($urandom), 3'($urandom));
            end
        end
        @(negedge i_ref_clk);
        check();
        stop_test();
    end
endmodule
`default_nettype wire
